// file: src/ssom_mapper.sv
// Status output mapper of a servo drive with APB configuration
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`include "ssom_cfg.svh"

// Overview of operation
// - Quadrature counts four edges; others count one
// - Each general output driven by one selected function
// - Fault output fixed, ON only when healthy
// - In-position when position error below threshold
// - Near-position when error below second threshold
// - At-speed when velocity feedback exceeds threshold
// - Speed-window when velocity error below threshold
// - Torque-limited when torque reaches its limit
// - Speed-limited when speed reaches its limit
// - Warning when any warning condition active
// - Absolute valid when encoder attached and read
// - Ready when unfaulted and enable allowed
// - In-motion while index controls and moving
// - Dwell while index controls but stationary
// - Homed once homing routine completes
// - Six functions show current index number bits while index controls
// - End-of-sequence when index motion completes
// - Brake function drives holding brake control
// - Setting turns fault code pins into outputs
// - Alarm line active whenever a fault exists
// - Three code bits name one of eight groups
// - Outputs active low; ON sinks the pin
// - OFF code pin means one; bit2 MSB
module ssom_mapper
    import ssom_pkg::*;
#(
    parameter int ERR_W = 32,
    parameter int CNT_W = 32
) (
    input wire logic core_clk,
    input wire logic reset_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Drive conditions
    input wire logic [ERR_W-1:0] position_error,
    input wire logic [ERR_W-1:0] velocity_feedback,
    input wire logic [ERR_W-1:0] velocity_error,
    input wire logic torque_at_limit,
    input wire logic speed_at_limit,
    input wire logic warning_active,
    input wire logic abs_encoder_attached,
    input wire logic abs_position_read_ok,
    input wire logic fault_active,
    input wire logic [2:0] fault_group,
    input wire logic enable_allowed,
    input wire logic index_active,
    input wire logic motor_moving,
    input wire logic homing_done,
    input wire logic [5:0] index_number,
    input wire logic index_complete,
    input wire logic brake_engage,
    // Pulse command inputs
    input wire logic fast_pulse_in,
    input wire logic fast_direction_in,
    // Output pins, low means ON (conducting), and the pulse count value
    output logic general_out_a_n,
    output logic general_out_b_n,
    output logic general_out_c_n,
    output logic fault_ok_n,
    output logic alarm_n,
    output logic fault_code_bit0,
    output logic fault_code_bit1,
    output logic fault_code_bit2,
    output logic holding_brake_out_n,
    output logic [CNT_W-1:0] pulse_count
);

    localparam int NSEL = 6;

    logic fault_remap_ff;
    logic [1:0] pmode_ff;
    logic [`SSOM_SEL_W-1:0] sel_ff [NSEL];
    logic [ERR_W-1:0] inpos_ff, nearpos_ff, spdwin_ff, atspd_ff;
    logic [NSEL-1:0] pin_on_ff;
    logic fault_ok_ff, alarm_ff, brake_ff;
    logic [2:0] code_ff;
    logic [CNT_W-1:0] count_ff;
    logic pulse_d_ff, dir_d_ff;
    logic [31:0] prdata_ff;
    logic [SSOM_FN_COUNT-1:0] func_vec;

    // APB decode
    wire apb_wr = psel && penable && pwrite;
    wire rd_setup = psel && !penable && !pwrite;
    wire hit_ctrl = paddr == `SSOM_OFS_CTRL;
    wire hit_sel_ab = paddr == `SSOM_OFS_SEL_AB;
    wire hit_sel_c = paddr == `SSOM_OFS_SEL_C;
    wire hit_inpos = paddr == `SSOM_OFS_INPOS;
    wire hit_nearpos = paddr == `SSOM_OFS_NEARPOS;
    wire hit_spdwin = paddr == `SSOM_OFS_SPDWIN;
    wire hit_atspd = paddr == `SSOM_OFS_ATSPD;
    wire hit_status = paddr == `SSOM_OFS_STATUS;
    wire hit_pins = paddr == `SSOM_OFS_PINS;
    wire hit_pcount = paddr == `SSOM_OFS_PCOUNT;
    wire hit_any = hit_ctrl || hit_sel_ab || hit_sel_c || hit_inpos || hit_nearpos ||
                   hit_spdwin || hit_atspd || hit_status || hit_pins || hit_pcount;

    // Per-register write strobes
    wire wr_ctrl = apb_wr && hit_ctrl;
    wire wr_sel_ab = apb_wr && hit_sel_ab;
    wire wr_sel_c = apb_wr && hit_sel_c;
    wire wr_inpos = apb_wr && hit_inpos;
    wire wr_nearpos = apb_wr && hit_nearpos;
    wire wr_spdwin = apb_wr && hit_spdwin;
    wire wr_atspd = apb_wr && hit_atspd;

    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit_any;
    assign prdata = prdata_ff;

    // Function evaluation
    wire [ERR_W-1:0] pos_mag = position_error[ERR_W-1] ? ERR_W'(-position_error) : position_error;
    wire [ERR_W-1:0] verr_mag = velocity_error[ERR_W-1] ? ERR_W'(-velocity_error) : velocity_error;
    wire [ERR_W-1:0] vfb_mag = velocity_feedback[ERR_W-1] ? ERR_W'(-velocity_feedback) : velocity_feedback;

    always_comb begin
        func_vec = '0;
        func_vec[SSOM_FN_IN_POSITION] = pos_mag < inpos_ff;
        func_vec[SSOM_FN_NEAR_POSITION] = pos_mag < nearpos_ff;
        func_vec[SSOM_FN_AT_SPEED] = vfb_mag > atspd_ff;
        func_vec[SSOM_FN_SPEED_WINDOW] = verr_mag < spdwin_ff;
        func_vec[SSOM_FN_TORQUE_LIMITED] = torque_at_limit;
        func_vec[SSOM_FN_SPEED_LIMITED] = speed_at_limit;
        func_vec[SSOM_FN_WARNING] = warning_active;
        func_vec[SSOM_FN_ABS_VALID] = abs_encoder_attached && abs_position_read_ok;
        func_vec[SSOM_FN_READY] = !fault_active && enable_allowed;
        func_vec[SSOM_FN_IN_MOTION] = index_active && motor_moving;
        func_vec[SSOM_FN_DWELL] = index_active && !motor_moving;
        func_vec[SSOM_FN_HOMED] = homing_done;
        func_vec[SSOM_FN_INDEX_BIT0] = index_active && index_number[0];
        func_vec[SSOM_FN_INDEX_BIT1] = index_active && index_number[1];
        func_vec[SSOM_FN_INDEX_BIT2] = index_active && index_number[2];
        func_vec[SSOM_FN_INDEX_BIT3] = index_active && index_number[3];
        func_vec[SSOM_FN_INDEX_BIT4] = index_active && index_number[4];
        func_vec[SSOM_FN_INDEX_BIT5] = index_active && index_number[5];
        func_vec[SSOM_FN_END_OF_SEQ] = index_complete;
        func_vec[SSOM_FN_BRAKE] = brake_engage;
    end

    // Per-output selection; unknown selector codes give OFF
    logic [NSEL-1:0] nxt_pin_on;
    genvar gi;
    generate
        for (gi = 0; gi < NSEL; gi++) begin : g_sel
            assign nxt_pin_on[gi] = (sel_ff[gi] < `SSOM_SEL_W'(SSOM_FN_COUNT)) ? func_vec[sel_ff[gi]] : 1'b0;
        end
    endgenerate

    // Fault code: OFF pin (high) means binary one
    wire [2:0] nxt_code_pins = fault_active ? fault_group : 3'b000;

    // Outputs registered every clock
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_on_ff <= '0;
        end else begin
            pin_on_ff <= nxt_pin_on;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_ok_ff <= 1'b0;
            alarm_ff <= 1'b0;
        end else begin
            fault_ok_ff <= !fault_active;
            alarm_ff <= fault_active;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            code_ff <= 3'b000;
        end else begin
            code_ff <= nxt_code_pins;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            brake_ff <= 1'b0;
        end else begin
            brake_ff <= brake_engage;
        end
    end

    // Active-low pin drive
    assign general_out_a_n = !pin_on_ff[0];
    assign general_out_b_n = !pin_on_ff[1];
    assign general_out_c_n = !pin_on_ff[2];
    assign fault_ok_n = !fault_ok_ff;
    assign alarm_n = !alarm_ff;
    assign holding_brake_out_n = !brake_ff;
    // Remapped pins carry extra outputs d..f, else the group code
    assign fault_code_bit0 = fault_remap_ff ? !pin_on_ff[3] : code_ff[0];
    assign fault_code_bit1 = fault_remap_ff ? !pin_on_ff[4] : code_ff[1];
    assign fault_code_bit2 = fault_remap_ff ? !pin_on_ff[5] : code_ff[2];

    // Pulse counter; inputs are sampled at the core clock, so the 3 MHz limit
    // leaves each level stable for several samples
    wire pulse_edge = fast_pulse_in ^ pulse_d_ff;
    wire dir_edge = fast_direction_in ^ dir_d_ff;
    wire pulse_rise = fast_pulse_in && !pulse_d_ff;
    wire dir_rise = fast_direction_in && !dir_d_ff;
    // Quadrature direction: A leads B counts up
    wire quad_up = pulse_edge ? (fast_pulse_in ^ fast_direction_in) : !(fast_pulse_in ^ fast_direction_in);
    logic [CNT_W-1:0] nxt_count;
    always_comb begin
        nxt_count = count_ff;
        case (ssom_pmode_t'(pmode_ff))
            SSOM_PM_QUADRATURE: begin
                if (pulse_edge ^ dir_edge) begin
                    nxt_count = quad_up ? CNT_W'(count_ff + 1'b1) : CNT_W'(count_ff - 1'b1);
                end
            end
            SSOM_PM_STEP_DIR: begin
                if (pulse_rise) begin
                    nxt_count = fast_direction_in ? CNT_W'(count_ff - 1'b1) : CNT_W'(count_ff + 1'b1);
                end
            end
            SSOM_PM_UP_DOWN: begin
                if (pulse_rise && !dir_rise) begin
                    nxt_count = CNT_W'(count_ff + 1'b1);
                end else if (dir_rise && !pulse_rise) begin
                    nxt_count = CNT_W'(count_ff - 1'b1);
                end
            end
            default: nxt_count = count_ff;
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= '0;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // Previous samples of the pulse lines for edge detection
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pulse_d_ff <= 1'b0;
            dir_d_ff <= 1'b0;
        end else begin
            pulse_d_ff <= fast_pulse_in;
            dir_d_ff <= fast_direction_in;
        end
    end
    assign pulse_count = count_ff;

    // Configuration registers
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            fault_remap_ff <= 1'b0;
            pmode_ff <= 2'b00;
        end else if (wr_ctrl) begin
            fault_remap_ff <= pwdata[`SSOM_CTRL_FAULT_REMAP];
            pmode_ff <= pwdata[`SSOM_CTRL_PMODE_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_ff[0] <= `SSOM_RST_SEL_A;
            sel_ff[1] <= `SSOM_RST_SEL_B;
            sel_ff[2] <= `SSOM_RST_SEL_C;
            sel_ff[3] <= `SSOM_RST_SEL_D;
            sel_ff[4] <= `SSOM_RST_SEL_E;
            sel_ff[5] <= `SSOM_RST_SEL_F;
        end else if (wr_sel_ab) begin
            sel_ff[0] <= pwdata[4:0];
            sel_ff[1] <= pwdata[12:8];
            sel_ff[2] <= pwdata[20:16];
        end else if (wr_sel_c) begin
            sel_ff[3] <= pwdata[4:0];
            sel_ff[4] <= pwdata[12:8];
            sel_ff[5] <= pwdata[20:16];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            inpos_ff <= ERR_W'(`SSOM_RST_THRESH);
        end else if (wr_inpos) begin
            inpos_ff <= ERR_W'(pwdata);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            nearpos_ff <= ERR_W'(`SSOM_RST_THRESH);
        end else if (wr_nearpos) begin
            nearpos_ff <= ERR_W'(pwdata);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            spdwin_ff <= ERR_W'(`SSOM_RST_THRESH);
        end else if (wr_spdwin) begin
            spdwin_ff <= ERR_W'(pwdata);
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            atspd_ff <= ERR_W'(`SSOM_RST_THRESH);
        end else if (wr_atspd) begin
            atspd_ff <= ERR_W'(pwdata);
        end
    end

    // Register read words
    wire [31:0] rd_ctrl_word = {29'h0000_0000, pmode_ff, fault_remap_ff};
    wire [31:0] rd_sel_ab_word = {11'h000, sel_ff[2], 3'h0, sel_ff[1], 3'h0, sel_ff[0]};
    wire [31:0] rd_sel_c_word = {11'h000, sel_ff[5], 3'h0, sel_ff[4], 3'h0, sel_ff[3]};
    wire [31:0] rd_inpos_word = 32'(inpos_ff);
    wire [31:0] rd_nearpos_word = 32'(nearpos_ff);
    wire [31:0] rd_spdwin_word = 32'(spdwin_ff);
    wire [31:0] rd_atspd_word = 32'(atspd_ff);
    wire [31:0] rd_status_word = {12'h000, func_vec};
    wire [31:0] rd_pins_word = {20'h0_0000, fault_ok_ff, alarm_ff, brake_ff, code_ff, pin_on_ff};
    wire [31:0] rd_pcount_word = 32'(count_ff);

    // Read mux
    logic [31:0] nxt_prdata;
    always_comb begin
        nxt_prdata = 32'h0000_0000;
        if (hit_ctrl) begin
            nxt_prdata = rd_ctrl_word;
        end else if (hit_sel_ab) begin
            nxt_prdata = rd_sel_ab_word;
        end else if (hit_sel_c) begin
            nxt_prdata = rd_sel_c_word;
        end else if (hit_inpos) begin
            nxt_prdata = rd_inpos_word;
        end else if (hit_nearpos) begin
            nxt_prdata = rd_nearpos_word;
        end else if (hit_spdwin) begin
            nxt_prdata = rd_spdwin_word;
        end else if (hit_atspd) begin
            nxt_prdata = rd_atspd_word;
        end else if (hit_status) begin
            nxt_prdata = rd_status_word;
        end else if (hit_pins) begin
            nxt_prdata = rd_pins_word;
        end else if (hit_pcount) begin
            nxt_prdata = rd_pcount_word;
        end
    end

    // Read data is captured in the setup cycle and held through the access
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_ff <= nxt_prdata;
        end
    end

endmodule

// file: src/ssom_cfg.svh
// Constants for the servo status output mapper
`ifndef SSOM_CFG_SVH
`define SSOM_CFG_SVH

// Bus register byte offsets
`define SSOM_OFS_CTRL      12'h000
`define SSOM_OFS_SEL_AB    12'h004
`define SSOM_OFS_SEL_C     12'h008
`define SSOM_OFS_INPOS     12'h00C
`define SSOM_OFS_NEARPOS   12'h010
`define SSOM_OFS_SPDWIN    12'h014
`define SSOM_OFS_ATSPD     12'h018
`define SSOM_OFS_STATUS    12'h01C
`define SSOM_OFS_PINS      12'h020
`define SSOM_OFS_PCOUNT    12'h024

// Field positions and selector field width
`define SSOM_CTRL_FAULT_REMAP 0
`define SSOM_CTRL_PMODE_LSB   1
`define SSOM_SEL_W            5

// Reset values
`define SSOM_RST_SEL_A    5'h00
`define SSOM_RST_SEL_B    5'h01
`define SSOM_RST_SEL_C    5'h0A
`define SSOM_RST_SEL_D    5'h02
`define SSOM_RST_SEL_E    5'h03
`define SSOM_RST_SEL_F    5'h04
`define SSOM_RST_THRESH   32'h0000_0010

// Pulse input limit and sampling need
`define SSOM_PULSE_MAX_HZ 3000000
`define SSOM_CLK_HZ       25000000

`endif

// file: src/ssom_pkg.sv
// Types for the servo status output mapper
package ssom_pkg;

    typedef enum logic [4:0] {
        SSOM_FN_IN_POSITION,
        SSOM_FN_NEAR_POSITION,
        SSOM_FN_AT_SPEED,
        SSOM_FN_SPEED_WINDOW,
        SSOM_FN_TORQUE_LIMITED,
        SSOM_FN_SPEED_LIMITED,
        SSOM_FN_WARNING,
        SSOM_FN_ABS_VALID,
        SSOM_FN_READY,
        SSOM_FN_IN_MOTION,
        SSOM_FN_DWELL,
        SSOM_FN_HOMED,
        SSOM_FN_INDEX_BIT0,
        SSOM_FN_INDEX_BIT1,
        SSOM_FN_INDEX_BIT2,
        SSOM_FN_INDEX_BIT3,
        SSOM_FN_INDEX_BIT4,
        SSOM_FN_INDEX_BIT5,
        SSOM_FN_END_OF_SEQ,
        SSOM_FN_BRAKE,
        SSOM_FN_COUNT
    } ssom_func_t;

    typedef enum logic [1:0] {
        SSOM_PM_QUADRATURE,
        SSOM_PM_STEP_DIR,
        SSOM_PM_UP_DOWN
    } ssom_pmode_t;

endpackage

// file: verif/ssom_ctrl_model.sv
// Machine controller model issuing pulse commands to the mapper
`timescale 1ns/100ps
module ssom_ctrl_model (
    input wire logic core_clk,
    input wire logic run,
    input wire logic [1:0] mode,
    input wire logic down,
    output logic fast_pulse_in,
    output logic fast_direction_in
);
    logic [1:0] div_ff = 2'd0;
    logic [1:0] ph_ff = 2'd0;
    // One phase step every third clock keeps each toggling line near 2 MHz
    always @(posedge core_clk) begin
        div_ff <= (run && div_ff != 2'd2) ? div_ff + 2'd1 : 2'd0;
        if (run && div_ff == 2'd2) ph_ff <= down ? ph_ff - 2'd1 : ph_ff + 2'd1;
    end
    // Quadrature: A leads B going up; other modes pulse once per four steps
    always_comb begin
        fast_pulse_in = mode == 2'd0 ? ph_ff[0] ^ ph_ff[1] : !(mode == 2'd2 && down) & ph_ff[1];
        fast_direction_in = mode == 2'd0 ? ph_ff[1] : (mode == 2'd1 ? down : down & ph_ff[1]);
    end
endmodule

// file: verif/ssom_mapper_assertions.sv
// Concurrent checks on the status output mapper ports
`timescale 1ns/100ps
`include "ssom_cfg.svh"
module ssom_mapper_assertions #(parameter int ERR_W = 32, parameter int CNT_W = 32) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic fault_active,
    input wire logic [2:0] fault_group,
    input wire logic enable_allowed,
    input wire logic index_active,
    input wire logic motor_moving,
    input wire logic brake_engage,
    input wire logic fast_pulse_in,
    input wire logic fast_direction_in,
    input wire logic general_out_a_n,
    input wire logic fault_ok_n,
    input wire logic alarm_n,
    input wire logic fault_code_bit0,
    input wire logic fault_code_bit1,
    input wire logic fault_code_bit2,
    input wire logic holding_brake_out_n,
    input wire logic [CNT_W-1:0] pulse_count
);
    logic remap_ff;
    logic [4:0] sel_a_ff;
    wire wr = psel & penable & pwrite & pready;
    wire [2:0] code = {fault_code_bit2, fault_code_bit1, fault_code_bit0};
    // Shadow of the remap bit and the first selector
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            remap_ff <= 1'b0;
            sel_a_ff <= `SSOM_RST_SEL_A;
        end else if (wr && paddr == `SSOM_OFS_CTRL) begin
            remap_ff <= pwdata[`SSOM_CTRL_FAULT_REMAP];
        end else if (wr && paddr == `SSOM_OFS_SEL_AB) begin
            sel_a_ff <= pwdata[4:0];
        end
    end
    default clocking dcb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    AST_FAULT_OK: assert property ($past(reset_n) |-> fault_ok_n == $past(fault_active))
        else $error("fault output does not follow fault state");
    AST_ALARM: assert property ($rose(fault_active) |=> !alarm_n && fault_ok_n)
        else $error("alarm line not active after fault");
    AST_FAULT_CODE: assert property ($past(reset_n) && !remap_ff |->
        code == ($past(fault_active) ? $past(fault_group) : 3'h0)) else $error("fault code pins wrong");
    AST_BRAKE: assert property ($rose(brake_engage) |=> $fell(holding_brake_out_n))
        else $error("brake output did not turn on");
    AST_COUNT_IDLE: assert property (($stable(fast_pulse_in) && $stable(fast_direction_in)) [*4]
        |=> $stable(pulse_count)) else $error("count moved without pulse edges");
    AST_READY: assert property ($past(reset_n) && $past(sel_a_ff) == 5'd8 |->
        general_out_a_n == !($past(enable_allowed) && !$past(fault_active))) else $error("ready output wrong");
    AST_MOTION: assert property ($past(reset_n) && $past(sel_a_ff) == 5'd9 |->
        general_out_a_n == !($past(index_active) && $past(motor_moving))) else $error("motion output wrong");
    AST_SEL_OFF: assert property ($past(reset_n) && $past(sel_a_ff) >= 5'd20 |-> general_out_a_n)
        else $error("unassigned output not off");
endmodule
bind ssom_mapper ssom_mapper_assertions #(.ERR_W(ERR_W), .CNT_W(CNT_W)) i_ssom_mapper_assertions (.*);

// file: verif/ssom_mapper_tb_top.sv
// Random and corner testbench for the status output mapper
`timescale 1ns/100ps
module ssom_mapper_tb_top;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, rmp, run = 1'b0, dn = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, pulse_count, rd, p0;
    logic [31:0] position_error, velocity_feedback, velocity_error;
    logic torque_at_limit, speed_at_limit, warning_active, abs_encoder_attached, abs_position_read_ok;
    logic fault_active, enable_allowed, index_active, motor_moving, homing_done, index_complete, brake_engage;
    logic [2:0] fault_group, ex;
    logic [5:0] index_number;
    logic fast_pulse_in, fast_direction_in, general_out_a_n, general_out_b_n, general_out_c_n;
    logic fault_ok_n, alarm_n, fault_code_bit0, fault_code_bit1, fault_code_bit2, holding_brake_out_n;
    logic [1:0] pm = 2'd0;
    logic [31:0] th [4] = '{default: 32'h0000_0010};
    logic [4:0] sel [6];
    logic [19:0] fv;
    integer seed = 32'hc8f6, num_errors = 0, check_count = 0, i = 0, j, tmo;
    ssom_mapper i_ssom_mapper (.*);
    ssom_ctrl_model i_ssom_ctrl_model (.core_clk, .run, .mode(pm), .down(dn), .fast_pulse_in, .fast_direction_in);
    always #20 core_clk = ~core_clk;
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        tmo = 0;
        do begin
            @(posedge core_clk);
            tmo++;
        end while (pready !== 1'b1 && tmo < 9);
        rd = prdata;
        if (pready !== 1'b1) begin
            num_errors++;
            end_sim();
        end
        chk({31'h0, pslverr}, {31'h0, e});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rnd();
        position_error <= (i % 3 == 0) ? th[0] : 32'($random(seed) % 80);
        velocity_feedback <= 32'($random(seed) % 80);
        velocity_error <= 32'($random(seed) % 80);
        {torque_at_limit, speed_at_limit, warning_active, abs_encoder_attached, abs_position_read_ok, fault_active,
            enable_allowed, index_active, motor_moving, homing_done, index_complete, brake_engage} <= 12'($random(seed));
        fault_group <= 3'($random(seed));
        index_number <= 6'($random(seed));
    endtask
    function automatic logic [31:0] mag(input logic [31:0] v);
        return v[31] ? -v : v;
    endfunction
    function automatic logic on(input logic [4:0] s);
        return s < 5'd20 ? fv[s] : 1'b0;
    endfunction
    initial begin
        rnd();
        repeat (15) @(posedge core_clk);
        #1;
        chk({23'h0, general_out_a_n, general_out_b_n, general_out_c_n, fault_ok_n, alarm_n, holding_brake_out_n,
            fault_code_bit2, fault_code_bit1, fault_code_bit0}, 32'h0000_01F8);
        @(posedge core_clk);
        reset_n <= 1'b1;
        $display("reset test done");
        for (j = 0; j < 7; j++) begin
            apb(1'b0, 12'(4 * j), 32'h0, 1'b0);
            chk(rd, j == 0 ? 32'h0 : j == 1 ? 32'h000A_0100 : j == 2 ? 32'h0004_0302 : 32'h0000_0010);
        end
        apb(1'b0, 12'h02C, 32'h0, 1'b1);
        chk(rd, 32'h0);
        $display("register test done");
        for (i = 0; i < 60; i++) begin
            for (j = 0; j < 4; j++) begin
                th[j] = 32'($random(seed) & 63);
                apb(1'b1, 12'(12 + 4 * j), th[j], 1'b0);
            end
            for (j = 0; j < 6; j++) sel[j] = 5'($unsigned($random(seed)) % 24);
            if (i < 4) sel[0] = i == 3 ? 5'd21 : 5'(8 + i);
            rmp = 1'($random(seed));
            apb(1'b1, 12'h000, {29'h0, pm, rmp}, 1'b0);
            apb(1'b1, 12'h004, {11'h0, sel[2], 3'h0, sel[1], 3'h0, sel[0]}, 1'b0);
            apb(1'b1, 12'h008, {11'h0, sel[5], 3'h0, sel[4], 3'h0, sel[3]}, 1'b0);
            rnd();
            repeat (3) @(posedge core_clk);
            #1;
            fv = {brake_engage, index_complete, index_number & {6{index_active}}, homing_done,
                index_active & !motor_moving, index_active & motor_moving, !fault_active & enable_allowed,
                abs_encoder_attached & abs_position_read_ok, warning_active, speed_at_limit, torque_at_limit,
                mag(velocity_error) < th[2], mag(velocity_feedback) > th[3], mag(position_error) < th[1],
                mag(position_error) < th[0]};
            ex = rmp ? ~{on(sel[5]), on(sel[4]), on(sel[3])} : (fault_active ? fault_group : 3'h0);
            chk({29'h0, general_out_a_n, general_out_b_n, general_out_c_n}, {29'h0, ~on(sel[0]), ~on(sel[1]),
                ~on(sel[2])});
            chk({29'h0, fault_code_bit2, fault_code_bit1, fault_code_bit0}, {29'h0, ex});
            chk({29'h0, fault_ok_n, alarm_n, holding_brake_out_n}, {29'h0, fault_active, !fault_active,
                !brake_engage});
            @(posedge core_clk);
            apb(1'b0, 12'h01C, 32'h0, 1'b0);
            chk(rd, {12'h0, fv});
        end
        $display("function test done");
        for (i = 0; i < 6; i++) begin
            pm <= 2'(i / 2);
            dn <= i[0];
            apb(1'b1, 12'h000, {29'h0, 2'(i / 2), 1'b0}, 1'b0);
            repeat (4) @(posedge core_clk);
            p0 = pulse_count;
            run <= 1'b1;
            repeat (48) @(posedge core_clk);
            run <= 1'b0;
            repeat (6) @(posedge core_clk);
            chk(pulse_count - p0, (i[0] ? -32'd1 : 32'd1) * (i < 2 ? 32'd16 : 32'd4));
        end
        $display("pulse test done");
        end_sim();
    end
endmodule
